//--- src/rst_sleep_io.sv
// reset sequencer, sleep/wake control, watchdog and the two i/o ports
// assumes a 100 MHz clock, an avalon-mm master and pins from outside the clock domain
`timescale 1ns/1ns
`include "rst_sleep_io_defs.svh"

module rst_sleep_io #(
    parameter int unsigned P_OST_CYC = `OST_CYC,
    parameter int unsigned P_WDT_CYC = `WDT_CYC,
    parameter int unsigned P_HXT_CYC = `HXT_CYC,
    parameter int unsigned P_LXT_CYC = `LXT_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_reset_pin_n,
    input wire logic [1:0] i_osc_mode,
    input wire logic i_sleep_instruction,
    input wire logic i_watchdog_clear_instr,
    input wire logic i_global_interrupt_on_instr,
    input wire logic i_global_interrupt_off_instr,
    input wire logic [6:0] i_port_a_in,
    output logic [6:0] o_port_a_out,
    output logic [6:0] o_port_a_oe,
    input wire logic [7:0] i_port_b_in,
    output logic [7:0] o_port_b_out,
    output logic [7:0] o_port_b_oe,
    output logic [7:0] o_pull_up_en,
    output logic [7:0] o_pull_down_en,
    output logic o_core_rst,
    output logic o_core_stall,
    output logic o_osc_enable,
    output logic o_pc_load,
    output logic [9:0] o_pc_value,
    output logic o_change_irq
);
    rst_sleep_io_pkg::seq_state_t state_q, state_d;
    logic [31:0] seq_cnt_q, seq_cnt_d, wdt_cnt_q;
    logic [7:0] presc_q, wdt_ctl_q, timer_ctl_q, pd_q, od_q, pu_q, status_q;
    logic [7:0] port_b_dir_q, port_b_data_q, port_b_ref_q, int_flag_q, int_mask_q;
    logic [6:0] port_a_dir_q, port_a_data_q;
    logic [7:0] wake_ctl_q, rdata;
    logic [6:0] pa_s1_q, pa_s2_q;
    logic [7:0] pb_s1_q, pb_s2_q;
    logic rp_s1_q, rp_s2_q, por_q, ack_q;

    function automatic logic [31:0] wake_cycles(input logic [1:0] mode);
        if (mode == rst_sleep_io_pkg::OSC_HXT)
            wake_cycles = P_HXT_CYC;
        else if (mode == rst_sleep_io_pkg::OSC_LXT)
            wake_cycles = P_LXT_CYC;
        else
            wake_cycles = `WAKE_RC_CLKS;
    endfunction

    function automatic logic ratio_hit(input logic [7:0] presc, input logic [2:0] sel);
        logic [7:0] mask;
        mask = (8'h02 << sel) - 8'h01;
        ratio_hit = ((presc & mask) == 8'h00);
    endfunction

    // pins cross into the clock domain through two flops before any use
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pa_s1_q <= 7'h00;
            pa_s2_q <= 7'h00;
            pb_s1_q <= 8'h00;
            pb_s2_q <= 8'h00;
            rp_s1_q <= 1'b1;
            rp_s2_q <= 1'b1;
        end
        else
        begin
            pa_s1_q <= i_port_a_in;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= i_port_b_in;
            pb_s2_q <= pb_s1_q;
            rp_s1_q <= i_reset_pin_n;
            rp_s2_q <= rp_s1_q;
        end
    end

    // bus: one wait state, then the answer
    wire bus_req = i_avs_read | i_avs_write;
    wire [5:0] idx = i_avs_address[7:2];
    wire in_hold = (state_q == rst_sleep_io_pkg::ST_HOLD);
    wire wr_en = ack_q & i_avs_write & i_avs_byteenable[0] & ~in_hold;
    wire [7:0] wd = i_avs_writedata[7:0];
    wire rd_port_b = ack_q & i_avs_read & (idx == `IDX_PORT_B_DATA);
    assign o_avs_waitrequest = bus_req & ~ack_q;

    wire wr_status = wr_en & (idx == `IDX_STATUS);
    wire wr_pa_data = wr_en & (idx == `IDX_PORT_A_DATA);
    wire wr_pb_data = wr_en & (idx == `IDX_PORT_B_DATA);
    wire wr_wake = wr_en & (idx == `IDX_WAKE_CONTROL);
    wire wr_flag = wr_en & (idx == `IDX_INTERRUPT_FLAG);
    wire wr_timer = wr_en & (idx == `IDX_TIMER_CONTROL);
    wire wr_pa_dir = wr_en & (idx == `IDX_PORT_A_DIRECTION);
    wire wr_pb_dir = wr_en & (idx == `IDX_PORT_B_DIRECTION);
    wire wr_pd = wr_en & (idx == `IDX_PULL_DOWN_CONTROL);
    wire wr_od = wr_en & (idx == `IDX_OPEN_DRAIN_CONTROL);
    wire wr_pu = wr_en & (idx == `IDX_PULL_UP_CONTROL);
    wire wr_wdt = wr_en & (idx == `IDX_WATCHDOG_CONTROL);
    wire wr_mask = wr_en & (idx == `IDX_INTERRUPT_MASK);

    // resistor-option pins read the pin level: attached resistor reads 0
    wire resistor_option_enable = wdt_ctl_q[`BIT_RESISTOR_OPTION];
    wire [6:0] port_a_view = pa_s2_q;

    always_comb
    begin
        if (idx == `IDX_PROGRAM_COUNTER)
            rdata = o_pc_value[7:0];
        else if (idx == `IDX_STATUS)
            rdata = status_q;
        else if (idx == `IDX_PORT_A_DATA)
            rdata = {1'b0, port_a_view};
        else if (idx == `IDX_PORT_B_DATA)
            rdata = pb_s2_q;
        else if (idx == `IDX_WAKE_CONTROL)
            rdata = wake_ctl_q;
        else if (idx == `IDX_INTERRUPT_FLAG)
            rdata = int_flag_q;
        else if (idx == `IDX_TIMER_CONTROL)
            rdata = timer_ctl_q;
        else if (idx == `IDX_PORT_A_DIRECTION)
            rdata = {1'b0, port_a_dir_q};
        else if (idx == `IDX_PORT_B_DIRECTION)
            rdata = port_b_dir_q;
        else if (idx == `IDX_PRESCALER_COUNT)
            rdata = presc_q;
        else if (idx == `IDX_PULL_DOWN_CONTROL)
            rdata = pd_q;
        else if (idx == `IDX_OPEN_DRAIN_CONTROL)
            rdata = od_q;
        else if (idx == `IDX_PULL_UP_CONTROL)
            rdata = pu_q;
        else if (idx == `IDX_WATCHDOG_CONTROL)
            rdata = wdt_ctl_q;
        else if (idx == `IDX_INTERRUPT_MASK)
            rdata = int_mask_q;
        else
            rdata = 8'h00;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ack_q <= 1'b0;
            o_avs_readdata <= 32'h0;
        end
        else
        begin
            ack_q <= bus_req & ~ack_q;
            if (i_avs_read & ~ack_q)
                o_avs_readdata <= {24'h0, rdata};
        end
    end

    // watchdog: prescaler down-counts, counter steps at the selected ratio
    wire wdt_en = wdt_ctl_q[`BIT_WDT_ENABLE];
    wire wdt_step = wdt_ctl_q[`BIT_WDT_PRESC_EN] ? ratio_hit(presc_q, wdt_ctl_q[2:0]) : 1'b1;
    wire wdt_to = wdt_en & wdt_step & ~in_hold & (wdt_cnt_q == P_WDT_CYC - 1);
    wire pin_rst = ~rp_s2_q;
    wire rst_event = pin_rst | wdt_to;
    wire sleep_go = (state_q == rst_sleep_io_pkg::ST_RUN) & i_sleep_instruction;
    wire wdt_clr = rst_event | in_hold | i_watchdog_clear_instr | sleep_go;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            presc_q <= `RST_ALL_ONES;
            wdt_cnt_q <= 32'h0;
        end
        else if (wdt_clr)
        begin
            presc_q <= `RST_ALL_ONES;
            wdt_cnt_q <= 32'h0;
        end
        else if (wdt_en)
        begin
            // prescaler only moves while it is assigned to the watchdog
            if (wdt_ctl_q[`BIT_WDT_PRESC_EN])
                presc_q <= presc_q - 8'h01;
            if (wdt_step)
                wdt_cnt_q <= wdt_cnt_q + 32'h1;
        end
    end

    // port b change detection against the reference caught on each read
    wire change = |(pb_s2_q ^ port_b_ref_q);
    wire change_wake_enable = wake_ctl_q[`BIT_CHANGE_WAKE_EN];
    wire change_interrupt_enable = int_mask_q[`BIT_CHANGE_INT_EN];
    wire gie = timer_ctl_q[`BIT_GLOBAL_INT];
    wire wake_lim_hit = (seq_cnt_q == wake_cycles(i_osc_mode) - 1);
    wire ost_hit = (seq_cnt_q == P_OST_CYC - 1);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            rst_sleep_io_pkg::ST_HOLD:
                if (!pin_rst && ost_hit)
                    state_d = rst_sleep_io_pkg::ST_RUN;
            rst_sleep_io_pkg::ST_RUN:
                if (i_sleep_instruction)
                    state_d = rst_sleep_io_pkg::ST_SLEEP;
            rst_sleep_io_pkg::ST_SLEEP:
                if (change && change_wake_enable)
                    state_d = rst_sleep_io_pkg::ST_WAKE;
            rst_sleep_io_pkg::ST_WAKE:
                if (wake_lim_hit)
                    state_d = rst_sleep_io_pkg::ST_RUN;
            default:
                state_d = rst_sleep_io_pkg::ST_HOLD;
        endcase
        if (rst_event)
            state_d = rst_sleep_io_pkg::ST_HOLD;
        if (rst_event || state_d != state_q || pin_rst)
            seq_cnt_d = 32'h0;
        else
            seq_cnt_d = seq_cnt_q + 32'h1;
    end

    wire hold_done = in_hold & (state_d == rst_sleep_io_pkg::ST_RUN);
    wire wake_done = (state_q == rst_sleep_io_pkg::ST_WAKE) & wake_lim_hit & ~rst_event;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= rst_sleep_io_pkg::ST_HOLD;
            seq_cnt_q <= 32'h0;
            por_q <= 1'b1;
            o_pc_load <= 1'b0;
            o_pc_value <= `PC_ZERO;
            o_change_irq <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            seq_cnt_q <= seq_cnt_d;
            if (hold_done)
                por_q <= 1'b0;
            o_pc_load <= hold_done | (wake_done & gie & change_interrupt_enable);
            if (rst_event | in_hold)
                o_pc_value <= `PC_ZERO;
            else if (wake_done & gie & change_interrupt_enable)
                o_pc_value <= `WAKE_VECTOR;
            o_change_irq <= int_flag_q[`BIT_CHANGE_FLAG] & change_interrupt_enable & gie;
        end
    end

    assign o_core_rst = in_hold;
    assign o_core_stall = (state_q != rst_sleep_io_pkg::ST_RUN);
    // oscillator stops only in sleep; any reset restarts it
    assign o_osc_enable = (state_q != rst_sleep_io_pkg::ST_SLEEP);

    // status: cause flags are hardware-owned, the rest writable
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            status_q <= `RST_STATUS;
        else
        begin
            if (wr_status)
            begin
                status_q[7:5] <= wd[7:5];
                status_q[2:0] <= wd[2:0];
            end
            if (wdt_to)
                status_q[`BIT_TIMEOUT_FLAG] <= 1'b0;
            else if (i_watchdog_clear_instr & ~in_hold)
            begin
                status_q[`BIT_TIMEOUT_FLAG] <= 1'b1;
                status_q[`BIT_POWERDOWN_FLAG] <= 1'b1;
            end
            else if (sleep_go)
                status_q[`BIT_POWERDOWN_FLAG] <= 1'b0;
        end
    end

    // configuration registers: fixed values at power-on; pin or watchdog reset keeps watchdog bits 5 and 3:0, mask bits 7:3 and wake bits other than 1
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            timer_ctl_q <= `RST_TIMER_CONTROL;
            pd_q <= `RST_ALL_ONES;
            pu_q <= `RST_ALL_ONES;
            od_q <= `RST_ALL_ZERO;
            wdt_ctl_q <= `RST_WDT_SET_MASK;
            int_mask_q <= `RST_ALL_ZERO;
            wake_ctl_q <= `RST_ALL_ZERO;
            port_a_dir_q <= `RST_DIR_A;
            port_b_dir_q <= `RST_ALL_ONES;
        end
        else if (rst_event)
        begin
            timer_ctl_q <= `RST_TIMER_CONTROL;
            pd_q <= `RST_ALL_ONES;
            pu_q <= `RST_ALL_ONES;
            od_q <= `RST_ALL_ZERO;
            wdt_ctl_q <= (wdt_ctl_q | `RST_WDT_SET_MASK) & ~`RST_WDT_CLR_MASK;
            int_mask_q <= int_mask_q & ~`RST_LOW3_CLR_MASK;
            wake_ctl_q[`BIT_CHANGE_WAKE_EN] <= 1'b0;
            port_a_dir_q <= `RST_DIR_A;
            port_b_dir_q <= `RST_ALL_ONES;
        end
        else
        begin
            if (wr_timer)
                timer_ctl_q <= wd;
            else if (i_global_interrupt_on_instr)
                timer_ctl_q[`BIT_GLOBAL_INT] <= 1'b1;
            else if (i_global_interrupt_off_instr)
                timer_ctl_q[`BIT_GLOBAL_INT] <= 1'b0;
            if (wr_pd)
                pd_q <= wd;
            if (wr_pu)
                pu_q <= wd;
            if (wr_od)
                od_q <= wd;
            if (wr_wdt)
                wdt_ctl_q <= wd;
            if (wr_mask)
                int_mask_q <= wd;
            if (wr_wake)
                wake_ctl_q <= wd;
            if (wr_pa_dir)
                port_a_dir_q <= wd[6:0];
            if (wr_pb_dir)
                port_b_dir_q <= wd;
        end
    end

    // data latches, reference and flags; a change in the clear cycle still sets
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            port_a_data_q <= 7'h00;
            port_b_data_q <= 8'h00;
            port_b_ref_q <= 8'h00;
            int_flag_q <= `RST_ALL_ZERO;
        end
        else
        begin
            if (wr_pa_data)
                port_a_data_q <= wd[6:0];
            if (wr_pb_data)
                port_b_data_q <= wd;
            if (rd_port_b | in_hold)
                port_b_ref_q <= pb_s2_q;
            if (rst_event | in_hold)
                int_flag_q <= int_flag_q & ~`RST_LOW3_CLR_MASK;
            else
            begin
                if (wr_flag)
                    int_flag_q <= wd;
                if (change)
                    int_flag_q[`BIT_CHANGE_FLAG] <= 1'b1;
            end
        end
    end

    // pins: direction, open-drain drives low only, reset floats everything
    wire [7:0] pb_drive = ~port_b_dir_q & (~od_q | ~port_b_data_q);
    wire [6:0] pa_drive = ~port_a_dir_q & {5'h1f, ~{2{resistor_option_enable}}};
    assign o_port_a_oe = in_hold ? 7'h00 : pa_drive;
    assign o_port_b_oe = in_hold ? 8'h00 : pb_drive;
    assign o_port_a_out = port_a_data_q;
    assign o_port_b_out = od_q & port_b_data_q ^ port_b_data_q | (~od_q & port_b_data_q);
    assign o_pull_up_en = ~pu_q;
    assign o_pull_down_en = ~pd_q;

    property p_reset_enters_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        rst_event |=> o_core_rst && o_pc_value == `PC_ZERO;
    endproperty
    a_reset_enters_hold: assert property (p_reset_enters_hold)
        else $error("reset event did not enter hold");

    property p_hold_length;
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(o_core_rst) |-> $past(seq_cnt_q) == P_OST_CYC - 1;
    endproperty
    a_hold_length: assert property (p_hold_length)
        else $error("hold released at wrong count");

    property p_pc_zero;
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(o_core_rst) |-> o_pc_load && o_pc_value == `PC_ZERO && o_osc_enable;
    endproperty
    a_pc_zero: assert property (p_pc_zero)
        else $error("no program counter zero load after reset");

    property p_ports_float;
        @(posedge i_core_clk) disable iff (i_rst)
        o_core_rst |-> o_port_a_oe == 7'h00 && o_port_b_oe == 8'h00;
    endproperty
    a_ports_float: assert property (p_ports_float)
        else $error("port driven during reset");

    property p_wdt_cleared;
        @(posedge i_core_clk) disable iff (i_rst)
        (rst_event || sleep_go) |=> wdt_cnt_q == 32'h0 && presc_q == `RST_ALL_ONES;
    endproperty
    a_wdt_cleared: assert property (p_wdt_cleared)
        else $error("watchdog not cleared");

    property p_reset_values;
        @(posedge i_core_clk) disable iff (i_rst)
        rst_event |=> timer_ctl_q == `RST_TIMER_CONTROL && od_q == `RST_ALL_ZERO
            && wdt_ctl_q[7] && !wdt_ctl_q[6] && !wdt_ctl_q[4] && int_mask_q[2:0] == 3'h0;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("register reset values wrong");

    property p_wake_vector;
        @(posedge i_core_clk) disable iff (i_rst)
        (wake_done && gie && change_interrupt_enable) |=> o_pc_load && o_pc_value == `WAKE_VECTOR;
    endproperty
    a_wake_vector: assert property (p_wake_vector)
        else $error("wake did not vector");

    property p_no_wake_without_enable;
        @(posedge i_core_clk) disable iff (i_rst)
        (state_q == rst_sleep_io_pkg::ST_SLEEP && !change_wake_enable && !rst_event)
            |=> state_q == rst_sleep_io_pkg::ST_SLEEP;
    endproperty
    a_no_wake_without_enable: assert property (p_no_wake_without_enable)
        else $error("woke without change wake enable");

    property p_change_flag;
        @(posedge i_core_clk) disable iff (i_rst)
        (change && !rst_event && !in_hold) |=> int_flag_q[`BIT_CHANGE_FLAG];
    endproperty
    a_change_flag: assert property (p_change_flag)
        else $error("port change not flagged");

    property p_open_drain;
        @(posedge i_core_clk) disable iff (i_rst)
        |(od_q & port_b_data_q) |-> (o_port_b_oe & od_q & port_b_data_q) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high");

    c_wdt_timeout: cover property (@(posedge i_core_clk) disable iff (i_rst) wdt_to);
    c_change_wake: cover property (@(posedge i_core_clk) disable iff (i_rst) wake_done);
    c_pin_reset: cover property (@(posedge i_core_clk) disable iff (i_rst) $fell(rp_s2_q));
endmodule

//--- src/rst_sleep_io_defs.svh
// register offsets, reset values and timing constants for the reset/sleep/io block
// assumes a 100 MHz core clock; offsets are word indices, byte address is index*4
`ifndef RST_SLEEP_IO_DEFS_SVH
`define RST_SLEEP_IO_DEFS_SVH

`define IDX_PROGRAM_COUNTER 6'h02
`define IDX_STATUS 6'h03
`define IDX_PORT_A_DATA 6'h05
`define IDX_PORT_B_DATA 6'h06
`define IDX_WAKE_CONTROL 6'h0e
`define IDX_INTERRUPT_FLAG 6'h0f
`define IDX_TIMER_CONTROL 6'h11
`define IDX_PORT_A_DIRECTION 6'h15
`define IDX_PORT_B_DIRECTION 6'h16
`define IDX_PRESCALER_COUNT 6'h1a
`define IDX_PULL_DOWN_CONTROL 6'h1b
`define IDX_OPEN_DRAIN_CONTROL 6'h1c
`define IDX_PULL_UP_CONTROL 6'h1d
`define IDX_WATCHDOG_CONTROL 6'h1e
`define IDX_INTERRUPT_MASK 6'h1f

`define BIT_WDT_ENABLE 7
`define BIT_EXT_INT_SEL 6
`define BIT_RESISTOR_OPTION 4
`define BIT_WDT_PRESC_EN 3
`define BIT_GLOBAL_INT 6
`define BIT_CHANGE_FLAG 1
`define BIT_CHANGE_INT_EN 1
`define BIT_CHANGE_WAKE_EN 1
`define BIT_TIMEOUT_FLAG 4
`define BIT_POWERDOWN_FLAG 3

`define RST_TIMER_CONTROL 8'hbf
`define RST_ALL_ONES 8'hff
`define RST_ALL_ZERO 8'h00
`define RST_DIR_A 7'h7f
`define RST_STATUS 8'h18
`define RST_WDT_SET_MASK 8'h80
`define RST_WDT_CLR_MASK 8'h50
`define RST_LOW3_CLR_MASK 8'h07
`define WAKE_VECTOR 10'h008
`define PC_ZERO 10'h000

`define CYC_PER_MS 100000
`define OST_MS 18
`define WDT_MS 18
`define WAKE_RC_CLKS 32
`define WAKE_HXT_MS 2
`define WAKE_LXT_MS 500
`define OST_CYC (`OST_MS * `CYC_PER_MS)
`define WDT_CYC (`WDT_MS * `CYC_PER_MS)
`define HXT_CYC (`WAKE_HXT_MS * `CYC_PER_MS + `WAKE_RC_CLKS)
`define LXT_CYC (`WAKE_LXT_MS * `CYC_PER_MS)

`endif

//--- src/rst_sleep_io_pkg.sv
// types shared by the reset/sleep/io block
// no assumptions beyond a SystemVerilog compiler
package rst_sleep_io_pkg;
    typedef enum logic [3:0] {
        ST_HOLD = 4'b0001,
        ST_RUN = 4'b0010,
        ST_SLEEP = 4'b0100,
        ST_WAKE = 4'b1000
    } seq_state_t;
    typedef enum logic [1:0] {
        OSC_RC = 2'b00,
        OSC_HXT = 2'b01,
        OSC_LXT = 2'b10
    } osc_mode_t;
endpackage

//--- verification/pin_model.sv
// far end of port b: a driver on every pin
// assumes the block's output wins where it drives
`timescale 1ns/1ns
module pin_model (
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_ext,
    output logic [7:0] o_pin
);
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

//--- verification/testbench.sv
// bus-task bench for the reset, sleep/wake and port block
// assumes pin_model on port b and 10 ns clock
`timescale 1ns/1ns
`include "rst_sleep_io_defs.svh"
module testbench;
    localparam int OST = 20;
    localparam int WDT = 400;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic i_reset_pin_n = 1'b1;
    logic i_sleep_instruction = 1'b0;
    logic i_watchdog_clear_instr = 1'b0;
    logic i_global_interrupt_on_instr = 1'b0;
    logic i_global_interrupt_off_instr = 1'b0;
    logic [7:0] i_avs_address = 8'h00;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [1:0] i_osc_mode = 2'h0;
    logic [7:0] ext_q = 8'h00;
    logic [6:0] pa_in = 7'h02;
    logic [7:0] i_port_b_in;
    logic [31:0] o_avs_readdata, rdata;
    logic o_avs_waitrequest, o_core_rst, o_core_stall, o_osc_enable, o_pc_load, o_change_irq;
    logic [9:0] o_pc_value, last_pc;
    logic [6:0] o_port_a_out, o_port_a_oe;
    logic [7:0] o_port_b_out, o_port_b_oe, o_pull_up_en, o_pull_down_en;
    int errors = 0;
    int n_compared = 0;
    int loads = 0;
    rst_sleep_io #(.P_OST_CYC(OST), .P_WDT_CYC(WDT), .P_HXT_CYC(40), .P_LXT_CYC(60)) dut (
        .i_core_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .i_avs_byteenable(4'hf), .o_avs_readdata, .o_avs_waitrequest, .i_reset_pin_n,
        .i_osc_mode, .i_sleep_instruction, .i_watchdog_clear_instr,
        .i_global_interrupt_on_instr, .i_global_interrupt_off_instr, .i_port_a_in(pa_in),
        .o_port_a_out, .o_port_a_oe, .i_port_b_in, .o_port_b_out, .o_port_b_oe,
        .o_pull_up_en, .o_pull_down_en, .o_core_rst, .o_core_stall, .o_osc_enable,
        .o_pc_load, .o_pc_value, .o_change_irq);
    pin_model far_end (.i_out(o_port_b_out), .i_oe(o_port_b_oe), .i_ext(ext_q),
        .o_pin(i_port_b_in));
    always #5 i_core_clk = ~i_core_clk;
    // pc load is a one-cycle pulse, so count it here rather than poll it
    always @(posedge i_core_clk)
    begin
        if (o_pc_load === 1'b1)
        begin
            loads <= loads + 1;
            last_pc <= o_pc_value;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tmo;
        errors++;
        $display("Error %0t: wait ran out", $time);
        wrap_up();
    endtask
    // request held until a rising edge sees waitrequest low; data taken at that edge
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        i_avs_address <= {idx, 2'b00};
        i_avs_write <= w;
        i_avs_read <= ~w;
        i_avs_writedata <= {24'h0, d};
        @(posedge i_core_clk);
        while (o_avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 20)
                tmo();
            @(posedge i_core_clk);
        end
        rdata = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v)
        begin
            @(negedge i_core_clk);
            n++;
            if (n > lim)
                tmo();
        end
        // second edge lets the pc-load counter settle before it is compared
        @(posedge i_core_clk);
        @(posedge i_core_clk);
    endtask
    initial
    begin
        int n;
        int l0;
        int dly [3] = '{`WAKE_RC_CLKS, 40, 60};
        logic [5:0] idx_t [10] = '{`IDX_TIMER_CONTROL, `IDX_PRESCALER_COUNT,
            `IDX_PULL_DOWN_CONTROL, `IDX_OPEN_DRAIN_CONTROL, `IDX_PULL_UP_CONTROL,
            `IDX_WATCHDOG_CONTROL, `IDX_PORT_A_DIRECTION, `IDX_PORT_B_DIRECTION, `IDX_STATUS,
            6'h3f};
        logic [7:0] val_t [10] = '{8'hbf, 8'hff, 8'hff, 8'h00, 8'hff, 8'h80, 8'h7f, 8'hff,
            8'h18, 8'h00};
        repeat (5) @(posedge i_core_clk);
        i_rst <= 1'b0;
        wait_lvl(o_core_rst, 1'b0, 200, n);
        chk(32'(n >= OST), 32'h1);
        chk(32'({loads[0], last_pc, o_osc_enable}), 32'h801);
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b0, idx_t[i], 8'h00);
            chk(rdata, 32'(val_t[i]));
        end
        bus(1'b0, `IDX_INTERRUPT_FLAG, 8'h00);
        chk(rdata & 32'h7, 32'h0);
        bus(1'b0, `IDX_INTERRUPT_MASK, 8'h00);
        chk(rdata & 32'h7, 32'h0);
        bus(1'b1, `IDX_WATCHDOG_CONTROL, 8'h00);
        for (int m = 0; m < 3; m++)
        begin
            i_osc_mode <= 2'(m);
            i_watchdog_clear_instr <= 1'b1;
            @(posedge i_core_clk);
            i_watchdog_clear_instr <= 1'b0;
            @(posedge i_core_clk);
            bus(1'b0, `IDX_PORT_B_DATA, 8'h00);
            bus(1'b1, `IDX_INTERRUPT_FLAG, 8'h00);
            bus(1'b1, `IDX_WAKE_CONTROL, 8'h02);
            bus(1'b1, `IDX_INTERRUPT_MASK, 8'h02);
            i_global_interrupt_on_instr <= (m == 0);
            i_global_interrupt_off_instr <= (m != 0);
            @(posedge i_core_clk);
            i_global_interrupt_on_instr <= 1'b0;
            i_global_interrupt_off_instr <= 1'b0;
            i_sleep_instruction <= 1'b1;
            @(posedge i_core_clk);
            i_sleep_instruction <= 1'b0;
            repeat (3) @(posedge i_core_clk);
            chk(32'({o_core_stall, o_osc_enable}), 32'h2);
            l0 = loads;
            ext_q <= ~ext_q;
            wait_lvl(o_core_stall, 1'b0, 200, n);
            chk(32'(n >= dly[m] && n <= dly[m] + 8), 32'h1);
            chk(32'(loads - l0), 32'(m == 0));
            chk(32'(o_change_irq), 32'(m == 0));
            if (m == 0)
                chk(32'(last_pc), 32'h8);
        end
        bus(1'b0, `IDX_STATUS, 8'h00);
        chk(rdata & 32'h18, 32'h10);
        bus(1'b1, `IDX_PORT_B_DIRECTION, 8'h00);
        bus(1'b1, `IDX_PORT_B_DATA, 8'ha5);
        chk(32'({o_port_b_oe, i_port_b_in}), 32'hffa5);
        bus(1'b1, `IDX_OPEN_DRAIN_CONTROL, 8'h0f);
        chk(32'(o_port_b_oe), 32'hfa);
        i_reset_pin_n <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        chk(32'(o_port_b_oe), 32'h0);
        i_reset_pin_n <= 1'b1;
        l0 = loads;
        wait_lvl(o_core_rst, 1'b0, 200, n);
        chk(32'({loads - l0, last_pc}), 32'h400);
        bus(1'b0, `IDX_OPEN_DRAIN_CONTROL, 8'h00);
        chk(rdata, 32'h0);
        bus(1'b0, `IDX_WATCHDOG_CONTROL, 8'h00);
        chk(rdata & 32'hd0, 32'h80);
        // watchdog came back enabled, so it must reset the block on its own
        wait_lvl(o_core_rst, 1'b1, WDT + 200, n);
        wait_lvl(o_core_rst, 1'b0, 200, n);
        bus(1'b0, `IDX_STATUS, 8'h00);
        chk(rdata & 32'h18, 32'h0);
        bus(1'b1, `IDX_PULL_UP_CONTROL, 8'h00);
        bus(1'b1, `IDX_PULL_DOWN_CONTROL, 8'hf0);
        chk(32'({o_pull_up_en, o_pull_down_en}), 32'hff0f);
        bus(1'b1, `IDX_PORT_A_DIRECTION, 8'h00);
        bus(1'b1, `IDX_WATCHDOG_CONTROL, 8'h10);
        chk(32'(o_port_a_oe), 32'h7c);
        bus(1'b1, `IDX_PORT_A_DATA, 8'h55);
        chk(32'(o_port_a_out), 32'h55);
        bus(1'b0, `IDX_PORT_A_DATA, 8'h00);
        chk(rdata, 32'h02);
        // change wake left disabled by the watchdog reset: only the pin may wake
        i_sleep_instruction <= 1'b1;
        @(posedge i_core_clk);
        i_sleep_instruction <= 1'b0;
        ext_q <= ~ext_q;
        repeat (80) @(posedge i_core_clk);
        chk(32'(o_core_stall), 32'h1);
        i_reset_pin_n <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        i_reset_pin_n <= 1'b1;
        wait_lvl(o_core_rst, 1'b0, 200, n);
        chk(32'(o_core_stall), 32'h0);
        wrap_up();
    end
endmodule
